/* File: core/dsm_pkg.sv */
// Constants and register map of the DMA status and collision monitor
//
// Behaviour
// - Per-channel read-only peripheral write collision flags
// - Status bits 31 to 4 read zero
// - Force and interrupt request collision flags
// - Last active channel holds transfer's channel
// - Last channel reads 1111 after reset
// - Buffer select bit: one means secondary
// - Force bit self-clears on done or disable
// - Primary and secondary 24-bit start addresses
package dsm_pkg;
  localparam int          NUM_CHAN       = 4;
  localparam int          ADDR_W         = 4;
  localparam int          START_ADDR_W   = 24;
  // Byte addresses of the status and control words
  localparam logic [3:0]  OFS_WCOL       = 4'h0;
  localparam logic [3:0]  OFS_RCOL       = 4'h4;
  localparam logic [3:0]  OFS_LAST       = 4'h8;
  localparam logic [3:0]  OFS_BSEL       = 4'hc;
  localparam logic [3:0]  OFS_FORCE      = 4'h1;
  // Word-aligned offsets for the control block
  localparam logic [5:0]  OFS_FORCE_W    = 6'h10;
  localparam logic [5:0]  OFS_COLCLR_W   = 6'h14;
  localparam logic [5:0]  OFS_IRQ_STAT   = 6'h18;
  localparam logic [5:0]  OFS_IRQ_MASK   = 6'h1c;
  localparam logic [3:0]  LAST_NONE      = 4'hf;
  localparam logic [3:0]  CHAN_RST       = 4'h0;
  localparam int          STAT_BITS      = 4;
  // Interrupt status bit positions
  localparam int          IRQ_WCOL       = 0;
  localparam int          IRQ_RCOL       = 1;
  localparam int          IRQ_DONE       = 2;
  localparam logic [2:0]  IRQ_RST        = 3'h0;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
endpackage

/* File: core/dsm_monitor.sv */
// DMA status and collision monitor with Avalon-MM register slave
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module dsm_monitor
  import dsm_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk_in,
  input  wire logic                reset_n_in,
  // Avalon-MM slave
  input  wire logic [5:0]          avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output logic [31:0]              avs_readdata_out,
  output logic                     avs_waitrequest_out,
  // Channel engine events
  input  wire logic [NUM_CHAN-1:0] write_collision_in,
  input  wire logic [NUM_CHAN-1:0] irq_request_in,
  input  wire logic [NUM_CHAN-1:0] xfer_done_in,
  input  wire logic [NUM_CHAN-1:0] buffer_toggle_in,
  input  wire logic [NUM_CHAN-1:0] channel_enable_in,
  // Start addresses from the channel register file
  input  wire logic [START_ADDR_W-1:0] primary_start_address_in [NUM_CHAN],
  input  wire logic [START_ADDR_W-1:0] secondary_start_address_in [NUM_CHAN],
  // Channel engine controls
  output logic [NUM_CHAN-1:0]      force_request_out,
  output logic [START_ADDR_W-1:0]  active_start_address_out [NUM_CHAN],
  output logic                     irq_out
);

  typedef struct packed {
    logic [NUM_CHAN-1:0] wcol;
    logic [NUM_CHAN-1:0] rcol;
    logic [3:0]          last;
    logic [NUM_CHAN-1:0] bsel;
    logic [NUM_CHAN-1:0] force_req;
    logic [2:0]          irq_stat;
    logic [2:0]          irq_mask;
    logic                ack;
    logic [31:0]         rdata;
  } dsm_state_s;

  dsm_state_s st;
  dsm_state_s next_st;

  // Lowest channel number that completed a transfer this cycle
  function automatic logic [3:0] dsm_first_chan(
    input logic [NUM_CHAN-1:0] v
  );
    logic [3:0] r;
    r = LAST_NONE;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Status word read-back, upper bits zero
  function automatic logic [31:0] dsm_word(input logic [3:0] v);
    return {28'h0000000, v};
  endfunction

  logic                req;
  logic                wr_go;
  logic                rd_go;
  logic [NUM_CHAN-1:0] rcol_hit;
  logic [NUM_CHAN-1:0] colclr;
  logic [2:0]          irq_clr;

  assign req      = avs_read_in | avs_write_in;
  // Writes land at the edge after the wait state, once waitrequest is low
  assign wr_go    = avs_write_in & st.ack & avs_byteenable_in[0];
  assign rd_go    = avs_read_in & ~st.ack;
  assign rcol_hit = st.force_req & irq_request_in;
  assign colclr   = (wr_go && avs_address_in == OFS_COLCLR_W)
                  ? avs_writedata_in[NUM_CHAN-1:0] : '0;
  assign irq_clr  = (wr_go && avs_address_in == OFS_IRQ_STAT)
                  ? avs_writedata_in[2:0] : 3'h0;

  always_comb begin
    next_st = st;
    next_st.ack = req & ~st.ack;
    next_st.wcol = (st.wcol & ~colclr) | write_collision_in;
    next_st.rcol = (st.rcol & ~colclr) | rcol_hit;
    if (|xfer_done_in) begin
      next_st.last = dsm_first_chan(xfer_done_in);
    end
    next_st.bsel = st.bsel ^ buffer_toggle_in;
    next_st.force_req = st.force_req & ~xfer_done_in & channel_enable_in;
    if (wr_go && avs_address_in == OFS_FORCE_W) begin
      next_st.force_req = next_st.force_req
                        | (avs_writedata_in[NUM_CHAN-1:0] & channel_enable_in);
    end
    if (wr_go && avs_address_in == OFS_IRQ_MASK) begin
      next_st.irq_mask = avs_writedata_in[2:0];
    end
    next_st.irq_stat = (st.irq_stat & ~irq_clr)
                     | {|xfer_done_in, |rcol_hit, |write_collision_in};
    next_st.rdata = UNMAPPED_DATA;
    if (rd_go) begin
      case (avs_address_in)
        {2'b00, OFS_WCOL}: next_st.rdata = dsm_word(st.wcol);
        {2'b00, OFS_RCOL}: next_st.rdata = dsm_word(st.rcol);
        {2'b00, OFS_LAST}: next_st.rdata = dsm_word(st.last);
        {2'b00, OFS_BSEL}: next_st.rdata = dsm_word(st.bsel);
        OFS_FORCE_W:       next_st.rdata = dsm_word(st.force_req);
        OFS_IRQ_STAT:      next_st.rdata = {29'h0, st.irq_stat};
        OFS_IRQ_MASK:      next_st.rdata = {29'h0, st.irq_mask};
        default:           next_st.rdata = UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      st.wcol      <= '0;
      st.rcol      <= '0;
      st.last      <= LAST_NONE;
      st.bsel      <= '0;
      st.force_req <= '0;
      st.irq_stat  <= IRQ_RST;
      st.irq_mask  <= IRQ_RST;
      st.ack       <= 1'b0;
      st.rdata     <= UNMAPPED_DATA;
    end else begin
      st <= next_st;
    end
  end

  assign avs_waitrequest_out = req & ~st.ack;
  assign avs_readdata_out    = st.rdata;
  assign force_request_out   = st.force_req;
  assign irq_out             = |(st.irq_stat & st.irq_mask);

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      active_start_address_out[i] = st.bsel[i]
        ? secondary_start_address_in[i] : primary_start_address_in[i];
    end
  end

  property p_wcol_set;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    write_collision_in[0] |=> st.wcol[0];
  endproperty
  a_wcol_set: assert property (p_wcol_set)
    else $error("write collision flag not set");

  property p_upper_zero;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (rd_go && avs_address_in[5:4] == 2'b00) |=> avs_readdata_out[31:4] == 0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("status upper bits not zero");

  property p_rcol;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (force_request_out[1] && irq_request_in[1]) |=> st.rcol[1];
  endproperty
  a_rcol: assert property (p_rcol)
    else $error("request collision missed");

  property p_last;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (xfer_done_in == 4'b0100) |=> st.last == 4'h2;
  endproperty
  a_last: assert property (p_last)
    else $error("last channel wrong");

  property p_last_legal;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    st.last <= 4'h3 || st.last == LAST_NONE;
  endproperty
  a_last_legal: assert property (p_last_legal)
    else $error("reserved last channel code");

  property p_bsel;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    buffer_toggle_in[0] |=> st.bsel[0] != $past(st.bsel[0]);
  endproperty
  a_bsel: assert property (p_bsel)
    else $error("buffer select did not toggle");

  property p_force_clr;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (!channel_enable_in[0] || xfer_done_in[0]) |=> !force_request_out[0];
  endproperty
  a_force_clr: assert property (p_force_clr)
    else $error("force not cleared");

  property p_addr_sel;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    st.bsel[3] |-> active_start_address_out[3]
                   == secondary_start_address_in[3];
  endproperty
  a_addr_sel: assert property (p_addr_sel)
    else $error("wrong start address selected");

  property p_sticky;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (st.wcol[2] && !colclr[2]) |=> st.wcol[2];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("collision flag lost");

  property p_wcol_ch3;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    write_collision_in[3] |=> st.wcol[3];
  endproperty
  a_wcol_ch3: assert property (p_wcol_ch3)
    else $error("channel 3 write collision flag not set");

  property p_wcol_no_spur;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (st.wcol == 4'h0 && write_collision_in == 4'h0) |=> st.wcol == 4'h0;
  endproperty
  a_wcol_no_spur: assert property (p_wcol_no_spur)
    else $error("write collision flag set without collision");

  property p_rcol_ch2;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (force_request_out[2] && irq_request_in[2]) |=> st.rcol[2];
  endproperty
  a_rcol_ch2: assert property (p_rcol_ch2)
    else $error("channel 2 request collision missed");

  property p_rcol_no_spur;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (st.rcol == 4'h0 && (force_request_out & irq_request_in) == 4'h0)
      |=> st.rcol == 4'h0;
  endproperty
  a_rcol_no_spur: assert property (p_rcol_no_spur)
    else $error("request collision flag set without collision");

  property p_last_hold;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    xfer_done_in == 4'h0 |=> $stable(st.last);
  endproperty
  a_last_hold: assert property (p_last_hold)
    else $error("last channel changed without transfer");

  property p_last_ch0;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    xfer_done_in[0] |=> st.last == 4'h0;
  endproperty
  a_last_ch0: assert property (p_last_ch0)
    else $error("last channel not 0");

  property p_last_ch3;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    xfer_done_in == 4'b1000 |=> st.last == 4'h3;
  endproperty
  a_last_ch3: assert property (p_last_ch3)
    else $error("last channel not 3");

  property p_last_rst;
    @(posedge ref_clk_in)
    !reset_n_in |=> st.last == LAST_NONE;
  endproperty
  a_last_rst: assert property (p_last_rst)
    else $error("last channel not idle code after reset");

  property p_bsel_rst;
    @(posedge ref_clk_in)
    !reset_n_in |=> st.bsel == 4'h0;
  endproperty
  a_bsel_rst: assert property (p_bsel_rst)
    else $error("buffer select not primary after reset");

  property p_col_rst;
    @(posedge ref_clk_in)
    !reset_n_in |=> (st.rcol == 4'h0 && st.wcol == 4'h0);
  endproperty
  a_col_rst: assert property (p_col_rst)
    else $error("collision flags not clear after reset");

  property p_force_rst;
    @(posedge ref_clk_in)
    !reset_n_in |=> force_request_out == 4'h0;
  endproperty
  a_force_rst: assert property (p_force_rst)
    else $error("force bits not clear after reset");

  property p_bsel_hold;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    buffer_toggle_in == 4'h0 |=> $stable(st.bsel);
  endproperty
  a_bsel_hold: assert property (p_bsel_hold)
    else $error("buffer select changed without toggle");

  property p_force_keep;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (force_request_out[1] && channel_enable_in[1] && !xfer_done_in[1]) |=>
      force_request_out[1];
  endproperty
  a_force_keep: assert property (p_force_keep)
    else $error("force bit cleared without done or disable");

  property p_addr_pri;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    !st.bsel[0] |-> active_start_address_out[0]
                    == primary_start_address_in[0];
  endproperty
  a_addr_pri: assert property (p_addr_pri)
    else $error("primary start address not selected");

  property p_rd_answer;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (avs_read_in && avs_waitrequest_out) |=> !avs_waitrequest_out;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered after one wait state");

  property p_irq_wcol;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    write_collision_in != 4'h0 |=> st.irq_stat[IRQ_WCOL];
  endproperty
  a_irq_wcol: assert property (p_irq_wcol)
    else $error("write collision event not recorded");

  property p_irq_rcol;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (force_request_out & irq_request_in) != 4'h0 |=> st.irq_stat[IRQ_RCOL];
  endproperty
  a_irq_rcol: assert property (p_irq_rcol)
    else $error("request collision event not recorded");

  property p_irq_done;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    xfer_done_in != 4'h0 |=> st.irq_stat[IRQ_DONE];
  endproperty
  a_irq_done: assert property (p_irq_done)
    else $error("transfer done event not recorded");

  property p_wcol_clr;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (st.wcol[2] && colclr[2] && !write_collision_in[2]) |=> !st.wcol[2];
  endproperty
  a_wcol_clr: assert property (p_wcol_clr)
    else $error("collision flag not cleared");

endmodule
`default_nettype wire

/* File: dv/dsm_chan_model.sv */
// Channel register file model feeding per-channel start addresses
`timescale 1ns/10ps
`default_nettype none
module dsm_chan_model
  import dsm_pkg::*;
(
  // Start addresses
  output logic [START_ADDR_W-1:0] pri_out [NUM_CHAN],
  output logic [START_ADDR_W-1:0] sec_out [NUM_CHAN]
);
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      pri_out[c] = 24'h100000 + 24'(c);
      sec_out[c] = 24'hf00000 + 24'(c);
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the DMA status and collision monitor
`timescale 1ns/10ps
`default_nettype none
module tb
  import dsm_pkg::*;
;
  logic                    ref_clk_in = 1'b0;
  logic                    reset_n_in = 1'b0;
  logic [5:0]              avs_address_in = 6'h00;
  logic                    avs_read_in = 1'b0;
  logic                    avs_write_in = 1'b0;
  logic [31:0]             avs_writedata_in = 32'h0;
  logic [31:0]             avs_readdata_out;
  logic                    avs_waitrequest_out;
  logic [NUM_CHAN-1:0]     wc = 4'h0, rq = 4'h0, dn = 4'h0, tg = 4'h0;
  logic [NUM_CHAN-1:0]     en = 4'hf;
  logic [NUM_CHAN-1:0]     force_request_out;
  logic                    irq_out;
  logic [START_ADDR_W-1:0] pri [NUM_CHAN];
  logic [START_ADDR_W-1:0] sec [NUM_CHAN];
  logic [START_ADDR_W-1:0] act [NUM_CHAN];
  logic [31:0]             exp_q [$];
  logic [31:0]             seed = 32'd59;
  logic [31:0]             r;
  int                      err_total = 0;
  int                      n_tests = 0;

  dsm_chan_model i_chan (.pri_out(pri), .sec_out(sec));
  dsm_monitor i_dut (.ref_clk_in, .reset_n_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hf),
    .avs_readdata_out, .avs_waitrequest_out, .write_collision_in(wc),
    .irq_request_in(rq), .xfer_done_in(dn), .buffer_toggle_in(tg),
    .channel_enable_in(en), .primary_start_address_in(pri),
    .secondary_start_address_in(sec), .force_request_out,
    .active_start_address_out(act), .irq_out);

  always #5 ref_clk_in = ~ref_clk_in;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= d;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 64);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (n >= 64) begin
      err_total++;
      stop_test();
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    bus(1'b0, a, 32'h0);
  endtask

  // One-cycle event pulses from the channel engines
  task automatic ev(input logic [3:0] w, input logic [3:0] q,
                    input logic [3:0] d, input logic [3:0] t);
    @(posedge ref_clk_in);
    {wc, rq, dn, tg} <= {w, q, d, t};
    @(posedge ref_clk_in);
    {wc, rq, dn, tg} <= 16'h0;
    @(posedge ref_clk_in);
    #1;
  endtask

  always @(posedge ref_clk_in) begin
    if (avs_read_in && avs_waitrequest_out === 1'b0) begin
      chk(avs_readdata_out, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    rd(6'h08, 32'hf);
    rd(6'h00, 32'h0);
    rd(6'h04, 32'h0);
    rd(6'h0c, 32'h0);
    rd(6'h20, UNMAPPED_DATA);
    $display("Test reset values done");
    r = xs() | 32'h5;
    ev(r[3:0], 4'h0, 4'h0, 4'h0);
    rd(6'h00, {28'h0, r[3:0]});
    bus(1'b1, 6'h00, 32'hffff_ffff);
    rd(6'h00, {28'h0, r[3:0]});
    #1 chk(irq_out, 1'b0);
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    #1 chk(irq_out, 1'b1);
    bus(1'b1, OFS_IRQ_STAT, 32'h7);
    #1 chk(irq_out, 1'b0);
    bus(1'b1, OFS_COLCLR_W, 32'hf);
    rd(6'h00, 32'h0);
    $display("Test write collision done");
    bus(1'b1, OFS_FORCE_W, 32'hf);
    #1 chk(force_request_out, 4'hf);
    ev(4'h0, 4'h6, 4'h0, 4'h0);
    rd(6'h04, 32'h6);
    ev(4'h0, 4'h0, 4'h8, 4'h0);
    chk(force_request_out, 4'h7);
    @(posedge ref_clk_in);
    en <= 4'he;
    repeat (2) @(posedge ref_clk_in);
    #1 chk(force_request_out, 4'h6);
    bus(1'b1, OFS_FORCE_W, 32'hf);
    rd(OFS_FORCE_W, 32'he);
    bus(1'b1, OFS_COLCLR_W, 32'h2);
    rd(6'h04, 32'h4);
    rd(OFS_IRQ_STAT, 32'h6);
    bus(1'b1, OFS_IRQ_MASK, 32'h4);
    #1 chk(irq_out, 1'b1);
    $display("Test force and request collision done");
    for (int c = 3; c >= 0; c--) begin
      ev(4'h0, 4'h0, 4'(1 << c), 4'h0);
      rd(6'h08, 32'(c));
    end
    ev(4'h0, 4'h0, 4'hc, 4'h0);
    rd(6'h08, 32'h2);
    $display("Test last channel done");
    ev(4'h0, 4'h0, 4'h0, 4'h2);
    rd(6'h0c, 32'h2);
    chk(act[1], sec[1]);
    chk(act[0], pri[0]);
    ev(4'h0, 4'h0, 4'h0, 4'h9);
    rd(6'h0c, 32'hb);
    chk(act[3], sec[3]);
    chk(act[0], sec[0]);
    $display("Test buffer select done");
    @(posedge ref_clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    rd(6'h08, 32'hf);
    rd(6'h0c, 32'h0);
    $display("Test reset in mid-run done");
    stop_test();
  end
endmodule
`default_nettype wire
